// file: core/timer_pair_pkg.sv
package timer_pair_pkg;

  localparam int WORD_W = 16;
  localparam int PRIO_W = 3;
  localparam int RATIO_W = 2;
  localparam int PRE_W = 8;
  localparam int ADDR_W = 8;

  // =====================================================
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_LOW_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_HIGH_CTRL  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_LOW_COUNT  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_HIGH_COUNT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_PER_LOW    = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_PER_HIGH   = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR  = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_IRQ_PRIO   = 8'h24;

  // =====================================================
  // control field positions
  localparam int BIT_CLK_SRC = 1;
  localparam int BIT_COMBINE = 3;
  localparam int BIT_RATIO_LO = 4;
  localparam int BIT_GATE = 6;
  localparam int BIT_IDLE_STOP = 13;
  localparam int BIT_ON = 15;
  localparam int PRIO_HI_LSB = 4;
  localparam logic [WORD_W-1:0] LOW_CTRL_MASK = 16'hA07A;
  localparam logic [WORD_W-1:0] HIGH_CTRL_MASK = 16'hA072;

  // =====================================================
  // reset values and limits
  localparam logic [WORD_W-1:0] CTRL_RST = 16'h0000;
  localparam logic [WORD_W-1:0] PERIOD_RST = 16'hFFFF;
  localparam logic [WORD_W-1:0] COUNT_MAX = 16'hFFFF;
  localparam logic [WORD_W-1:0] COUNT_ZERO = 16'h0000;
  localparam logic [PRE_W-1:0] PRE_ZERO = 8'h00;
  localparam logic [PRE_W-1:0] PRE_STEP = 8'h01;

  // prescale terminal counts for ratios 1, 8, 64, 256
  localparam logic [PRE_W-1:0] PRESCALE_LAST [4] =
    '{8'h00, 8'h07, 8'h3F, 8'hFF};

endpackage

// file: core/tick_gen.sv
`timescale 1ns/1ps
module tick_gen (
  input  wire logic                           mclk,
  input  wire logic                           rst,
  input  wire logic                           run,
  input  wire logic                           clock_source_select,
  input  wire logic                           gate_enable,
  input  wire logic [timer_pair_pkg::RATIO_W-1:0] prescale_ratio,
  input  wire logic                           ext_level,
  input  wire logic                           ext_rise,
  output logic                                count_pulse_q
);
  import timer_pair_pkg::*;

  logic [PRE_W-1:0] pre_q;
  logic             src_tick;

  // =====================================================
  // count source by mode
  always_comb begin
    if (!run) begin
      src_tick = 1'b0;
    end else if (clock_source_select) begin
      src_tick = ext_rise;
    end else if (gate_enable) begin
      src_tick = ext_level;
    end else begin
      src_tick = 1'b1;
    end
  end

  // =====================================================
  // prescaler
  always_ff @(posedge mclk) begin
    if (rst || !run) begin
      pre_q <= PRE_ZERO;
      count_pulse_q <= 1'b0;
    end else if (src_tick) begin
      if (pre_q >= PRESCALE_LAST[prescale_ratio]) begin
        pre_q <= PRE_ZERO;
        count_pulse_q <= 1'b1;
      end else begin
        pre_q <= pre_q + PRE_STEP;
        count_pulse_q <= 1'b0;
      end
    end else begin
      count_pulse_q <= 1'b0;
    end
  end

  a_pulse_needs_run: assert property (
    @(posedge mclk) disable iff (rst)
    count_pulse_q |-> $past(run) && $past(src_tick))
    else $error("count pulse without running source");

endmodule

// file: core/timer_pair.sv
// Operation
// - combine clear gives independent 16-bit timers
// - combine bit three joins 32-bit counter
// - upper word high half, lower word low
// - combined uses lower control, upper idle-stop only
// - combined interrupt uses upper flag and enable
// - only lower/upper fixed pairs combine
// - timer, gated timer, synchronous counter modes
// - 2-bit prescaler; lower ratio when combined
// - clock source and gate bits select mode
// - independent compare against own period
// - 32-bit period from both period registers
// - each interrupt has enable and priority
// - mode encoding of source and gate bits
// - internal clock or external count pin edges
//
// Added by the designer: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
module timer_pair (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        external_count_clock_low,
  input  wire logic        external_count_clock_high,
  input  wire logic        cpu_idle,
  output logic             irq,
  output logic [timer_pair_pkg::PRIO_W-1:0] irq_priority
);
  import timer_pair_pkg::*;

  // =====================================================
  // state
  logic [WORD_W-1:0] ctrl_q [2];
  logic [WORD_W-1:0] cnt_q [2];
  logic [WORD_W-1:0] per_q [2];
  logic [1:0]        stat_q;
  logic [1:0]        en_q;
  logic [PRIO_W-1:0] prio_q [2];
  logic [ADDR_W-1:0] addr_q;
  logic              wr_pend_q;
  logic [31:0]       rd_d;
  logic              take;
  logic [1:0]        ext_raw;
  logic [1:0]        ext_lvl;
  logic [1:0]        ext_rise;
  logic [1:0]        run;
  logic [1:0]        pulse;
  logic [1:0]        ev;
  logic [1:0]        eff_en;
  logic              combined;
  logic              match_lo;
  logic              match_hi;
  logic              match32;
  logic              wr_lo_ctrl;
  logic              wr_hi_ctrl;
  logic              wr_lo_cnt;
  logic              wr_hi_cnt;
  logic              wr_per_lo;
  logic              wr_per_hi;
  logic              wr_en;
  logic              wr_clr;
  logic              wr_prio;
  logic [1:0]        pend;
  logic [PRIO_W-1:0] prio_d;

  // lower word is timer two (or four), upper three (or five)
  assign combined = ctrl_q[0][BIT_COMBINE];
  assign ext_raw = {external_count_clock_high, external_count_clock_low};

  // =====================================================
  // bus slave: address phase capture
  assign take = hsel && hready && htrans[1];

  // read mux, unmapped reads zero
  always_comb begin
    rd_d = 32'h0000_0000;
    if (haddr[ADDR_W-1:0] == OFF_LOW_CTRL) begin
      rd_d[WORD_W-1:0] = ctrl_q[0];
    end else if (haddr[ADDR_W-1:0] == OFF_HIGH_CTRL) begin
      rd_d[WORD_W-1:0] = ctrl_q[1];
    end else if (haddr[ADDR_W-1:0] == OFF_LOW_COUNT) begin
      rd_d[WORD_W-1:0] = cnt_q[0];
    end else if (haddr[ADDR_W-1:0] == OFF_HIGH_COUNT) begin
      rd_d[WORD_W-1:0] = cnt_q[1];
    end else if (haddr[ADDR_W-1:0] == OFF_PER_LOW) begin
      rd_d[WORD_W-1:0] = per_q[0];
    end else if (haddr[ADDR_W-1:0] == OFF_PER_HIGH) begin
      rd_d[WORD_W-1:0] = per_q[1];
    end else if (haddr[ADDR_W-1:0] == OFF_IRQ_STATUS) begin
      rd_d[1:0] = stat_q;
    end else if (haddr[ADDR_W-1:0] == OFF_IRQ_ENABLE) begin
      rd_d[1:0] = en_q;
    end else if (haddr[ADDR_W-1:0] == OFF_IRQ_PRIO) begin
      rd_d[PRIO_W-1:0] = prio_q[0];
      rd_d[PRIO_HI_LSB+PRIO_W-1:PRIO_HI_LSB] = prio_q[1];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      addr_q <= OFF_LOW_CTRL;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= take && hwrite;
      if (take) begin
        addr_q <= haddr[ADDR_W-1:0];
      end
      if (take && !hwrite) begin
        hrdata <= rd_d;
      end
    end
  end

  // data phase write strobes
  always_comb begin
    wr_lo_ctrl = 1'b0;
    wr_hi_ctrl = 1'b0;
    wr_lo_cnt = 1'b0;
    wr_hi_cnt = 1'b0;
    wr_per_lo = 1'b0;
    wr_per_hi = 1'b0;
    wr_en = 1'b0;
    wr_clr = 1'b0;
    wr_prio = 1'b0;
    if (!wr_pend_q) begin
      wr_en = 1'b0;
    end else if (addr_q == OFF_LOW_CTRL) begin
      wr_lo_ctrl = 1'b1;
    end else if (addr_q == OFF_HIGH_CTRL) begin
      wr_hi_ctrl = 1'b1;
    end else if (addr_q == OFF_LOW_COUNT) begin
      wr_lo_cnt = 1'b1;
    end else if (addr_q == OFF_HIGH_COUNT) begin
      wr_hi_cnt = 1'b1;
    end else if (addr_q == OFF_PER_LOW) begin
      wr_per_lo = 1'b1;
    end else if (addr_q == OFF_PER_HIGH) begin
      wr_per_hi = 1'b1;
    end else if (addr_q == OFF_IRQ_ENABLE) begin
      wr_en = 1'b1;
    end else if (addr_q == OFF_IRQ_CLEAR) begin
      wr_clr = 1'b1;
    end else if (addr_q == OFF_IRQ_PRIO) begin
      wr_prio = 1'b1;
    end
  end

  // =====================================================
  // configuration registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q[0] <= CTRL_RST;
      ctrl_q[1] <= CTRL_RST;
      per_q[0] <= PERIOD_RST;
      per_q[1] <= PERIOD_RST;
      en_q <= 2'h0;
      prio_q[0] <= 3'h0;
      prio_q[1] <= 3'h0;
    end else begin
      if (wr_lo_ctrl) begin
        ctrl_q[0] <= hwdata[WORD_W-1:0] & LOW_CTRL_MASK;
      end
      if (wr_hi_ctrl) begin
        ctrl_q[1] <= hwdata[WORD_W-1:0] & HIGH_CTRL_MASK;
      end
      if (wr_per_lo) begin
        per_q[0] <= hwdata[WORD_W-1:0];
      end
      if (wr_per_hi) begin
        per_q[1] <= hwdata[WORD_W-1:0];
      end
      if (wr_en) begin
        en_q <= hwdata[1:0];
      end
      if (wr_prio) begin
        prio_q[0] <= hwdata[PRIO_W-1:0];
        prio_q[1] <= hwdata[PRIO_HI_LSB+PRIO_W-1:PRIO_HI_LSB];
      end
    end
  end

  // =====================================================
  // run control; upper controls ignored when combined, except upper idle-stop
  assign run[0] = ctrl_q[0][BIT_ON] && !(cpu_idle &&
    (combined ? ctrl_q[1][BIT_IDLE_STOP] : ctrl_q[0][BIT_IDLE_STOP]));
  assign run[1] = !combined && ctrl_q[1][BIT_ON] &&
    !(cpu_idle && ctrl_q[1][BIT_IDLE_STOP]);

  // =====================================================
  // per timer pin sync and count tick
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_unit
      logic s1_q;
      logic s2_q;
      logic s3_q;

      always_ff @(posedge mclk) begin
        if (rst) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end else begin
          s1_q <= ext_raw[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end

      assign ext_lvl[i] = s2_q;
      assign ext_rise[i] = s2_q && !s3_q;

      tick_gen u_tick (
        .mclk                (mclk),
        .rst                 (rst),
        .run                 (run[i]),
        .clock_source_select (ctrl_q[i][BIT_CLK_SRC]),
        .gate_enable         (ctrl_q[i][BIT_GATE]),
        .prescale_ratio      (ctrl_q[i][BIT_RATIO_LO+RATIO_W-1:BIT_RATIO_LO]),
        .ext_level           (ext_lvl[i]),
        .ext_rise            (ext_rise[i]),
        .count_pulse_q       (pulse[i])
      );
    end
  endgenerate

  // =====================================================
  // counters
  assign match_lo = cnt_q[0] == per_q[0];
  assign match_hi = cnt_q[1] == per_q[1];
  assign match32 = {cnt_q[1], cnt_q[0]} == {per_q[1], per_q[0]};

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_q[0] <= COUNT_ZERO;
      cnt_q[1] <= COUNT_ZERO;
    end else begin
      if (combined && pulse[0]) begin
        if (match32) begin
          cnt_q[0] <= COUNT_ZERO;
          cnt_q[1] <= COUNT_ZERO;
        end else begin
          cnt_q[0] <= cnt_q[0] + 16'h0001;
          if (cnt_q[0] == COUNT_MAX) begin
            cnt_q[1] <= cnt_q[1] + 16'h0001;
          end
        end
      end else if (!combined) begin
        if (pulse[0]) begin
          cnt_q[0] <= match_lo ? COUNT_ZERO : cnt_q[0] + 16'h0001;
        end
        if (pulse[1]) begin
          cnt_q[1] <= match_hi ? COUNT_ZERO : cnt_q[1] + 16'h0001;
        end
      end
      if (wr_lo_cnt) begin
        cnt_q[0] <= hwdata[WORD_W-1:0];
      end
      if (wr_hi_cnt) begin
        cnt_q[1] <= hwdata[WORD_W-1:0];
      end
    end
  end

  // =====================================================
  // interrupt flags, set wins over clear
  assign ev[0] = !combined && pulse[0] && match_lo;
  assign ev[1] = combined ? (pulse[0] && match32)
                          : (pulse[1] && match_hi);
  assign eff_en = {en_q[1], en_q[0] && !combined};
  assign pend = stat_q & eff_en;

  always_ff @(posedge mclk) begin
    if (rst) begin
      stat_q <= 2'h0;
    end else begin
      stat_q <= (stat_q & ~(wr_clr ? hwdata[1:0] : 2'h0)) | ev;
    end
  end

  // highest priority among pending sources
  always_comb begin
    prio_d = 3'h0;
    if (pend[0]) begin
      prio_d = prio_q[0];
    end
    if (pend[1] && (!pend[0] || prio_q[1] > prio_q[0])) begin
      prio_d = prio_q[1];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq <= 1'b0;
      irq_priority <= 3'h0;
    end else begin
      irq <= |pend;
      irq_priority <= prio_d;
    end
  end

  // =====================================================
  // checks
  a_lo_period_wrap: assert property (
    @(posedge mclk) disable iff (rst)
    (!combined && pulse[0] && match_lo && !wr_lo_cnt && !wr_clr)
    |=> cnt_q[0] == COUNT_ZERO && stat_q[0])
    else $error("lower timer did not wrap on period");
  a_lo_flag_combined: assert property (
    @(posedge mclk) disable iff (rst)
    $rose(stat_q[0]) |-> !$past(combined))
    else $error("lower flag set in combined mode");
  a_upper_carry: assert property (
    @(posedge mclk) disable iff (rst)
    (combined && pulse[0] && !match32 && cnt_q[0] == COUNT_MAX
     && !wr_hi_cnt) |=> cnt_q[1] == $past(cnt_q[1]) + 16'h0001)
    else $error("upper word missed carry");
  a_upper_hold: assert property (
    @(posedge mclk) disable iff (rst)
    (combined && cnt_q[0] != COUNT_MAX && !wr_hi_cnt
     && !(pulse[0] && match32)) |=> $stable(cnt_q[1]))
    else $error("upper word moved without carry");
  a_wrap32: assert property (
    @(posedge mclk) disable iff (rst)
    (combined && pulse[0] && match32 && !wr_lo_cnt && !wr_hi_cnt
     && !wr_clr) |=> cnt_q[0] == COUNT_ZERO && cnt_q[1] == COUNT_ZERO
     && stat_q[1])
    else $error("32-bit timer did not wrap on period");
  a_off_no_count: assert property (
    @(posedge mclk) disable iff (rst)
    (!ctrl_q[0][BIT_ON] ##1 (!ctrl_q[0][BIT_ON] && !wr_lo_cnt))
    |=> $stable(cnt_q[0]))
    else $error("lower counter moved while off");
  a_irq_follows: assert property (
    @(posedge mclk) disable iff (rst)
    (|pend) |=> irq ##0 (irq_priority >= $past(prio_q[1])
    || !$past(pend[1])))
    else $error("interrupt not raised for pending flag");
  a_irq_low_masked: assert property (
    @(posedge mclk) disable iff (rst)
    (combined && !stat_q[1]) |=> !irq)
    else $error("lower enable leaked in combined mode");
  a_bus_okay: assert property (
    @(posedge mclk) disable iff (rst)
    $past(take) |-> hreadyout && !hresp)
    else $error("bus answer not ready or not okay");

endmodule

// file: verification/timer_pair_tb.sv
`timescale 1ns/1ps
module timer_pair_tb;
  import timer_pair_pkg::*;
  logic        mclk, rst, hsel, hwrite, hreadyout, hresp, irq;
  logic        ext_low, ext_high, cpu_idle, rd_chk;
  logic [31:0] haddr, hwdata, hrdata, last_rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, irq_priority;
  logic [39:0] exp_q[$];
  logic [39:0] note;
  logic [15:0] per;
  int          n_fail, n_tests, n, seed, lo;
  int          cyc = 0;
  int          divs[4] = '{1, 8, 64, 256};

  timer_pair u_timer_pair (.mclk(mclk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .external_count_clock_low(ext_low),
    .external_count_clock_high(ext_high), .cpu_idle(cpu_idle),
    .irq(irq), .irq_priority(irq_priority));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // =====================================================
  // checking and closing
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // read results compared against the oldest note
  always @(posedge mclk) begin
    if (rd_chk && hreadyout) begin
      note = exp_q.pop_front();
      check($sformatf("reg %h", note[39:32]), hrdata, note[31:0]);
      check("hresp", {31'h0, hresp}, 32'h0);
    end
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      complete_run();
    end
  end

  // =====================================================
  // bus tasks
  task automatic xfer(input logic [7:0] a, input logic wr,
                      input logic [31:0] d, input logic chk);
    haddr <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'b10;
    @(posedge mclk);
    while (hreadyout !== 1'b1)
      @(posedge mclk);
    htrans <= 2'b00;
    hwdata <= wr ? d : 32'h00000000;
    rd_chk <= !wr && chk;
    if (!wr && chk)
      exp_q.push_back({a, d});
    @(posedge mclk);
    while (hreadyout !== 1'b1)
      @(posedge mclk);
    last_rd = hrdata;
    rd_chk <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d, 1'b0);
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, e, 1'b1);
  endtask

  task automatic wait_irq();
    n = 0;
    while (irq !== 1'b1 && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    @(posedge mclk);
  endtask

  // =====================================================
  // main sequence
  initial begin
    seed = 32'h39cd;
    rst = 1'b1;
    hsel = 1'b1;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    ext_low = 1'b0;
    ext_high = 1'b0;
    cpu_idle = 1'b0;
    rd_chk = 1'b0;
    n_fail = 0;
    n_tests = 0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(OFF_LOW_CTRL, 32'h00000000);
    rd(OFF_PER_HIGH, 32'h0000FFFF);
    rd(OFF_IRQ_STATUS, 32'h00000000);
    rd(8'h40, 32'h00000000);
    $display("test reset values done");

    per = 16'h0004 + (16'($random(seed)) & 16'h0007);
    wr(OFF_PER_LOW, {16'h0000, per});
    wr(OFF_IRQ_ENABLE, 32'h00000001);
    wr(OFF_IRQ_PRIO, 32'h00000035);
    for (int r = 0; r < 4; r++) begin
      wr(OFF_LOW_COUNT, 32'h00000000);
      wr(OFF_LOW_CTRL, 32'h00008000 | (r << 4));
      wait_irq();
      lo = (int'(per) + 1) * divs[r] - 2;
      check("period time", 32'(n >= lo && n <= lo + 8), 32'h1);
      repeat (2) @(posedge mclk);
      check("priority", {29'h0, irq_priority}, 32'h5);
      wr(OFF_LOW_CTRL, 32'h00000000);
      rd(OFF_IRQ_STATUS, 32'h00000001);
      wr(OFF_IRQ_CLEAR, 32'h00000001);
      rd(OFF_IRQ_STATUS, 32'h00000000);
      check("irq cleared", {31'h0, irq}, 32'h0);
    end
    wr(OFF_LOW_COUNT, 32'h00001234);
    repeat (8) @(posedge mclk);
    rd(OFF_LOW_COUNT, 32'h00001234);
    $display("test prescaled period done");

    wr(OFF_LOW_COUNT, 32'h0000FFF0);
    wr(OFF_HIGH_COUNT, 32'h00000000);
    wr(OFF_PER_LOW, 32'h00000005);
    wr(OFF_PER_HIGH, 32'h00000001);
    wr(OFF_IRQ_ENABLE, 32'h00000003);
    wr(OFF_HIGH_CTRL, 32'h00000030);
    wr(OFF_LOW_CTRL, 32'h00008008);
    wait_irq();
    check("pair time", 32'(n >= 20 && n <= 28), 32'h1);
    repeat (2) @(posedge mclk);
    check("pair priority", {29'h0, irq_priority}, 32'h3);
    wr(OFF_LOW_CTRL, 32'h00000000);
    rd(OFF_IRQ_STATUS, 32'h00000002);
    rd(OFF_HIGH_COUNT, 32'h00000000);
    wr(OFF_IRQ_CLEAR, 32'h00000003);
    wr(OFF_HIGH_CTRL, 32'h00000000);
    $display("test combined pair done");

    wr(OFF_PER_LOW, 32'h0000FFFF);
    wr(OFF_LOW_COUNT, 32'h00000000);
    wr(OFF_LOW_CTRL, 32'h00008040);
    repeat (20) @(posedge mclk);
    rd(OFF_LOW_COUNT, 32'h00000000);
    ext_low <= 1'b1;
    repeat (40) @(posedge mclk);
    ext_low <= 1'b0;
    repeat (10) @(posedge mclk);
    xfer(OFF_LOW_COUNT, 1'b0, 32'h0, 1'b0);
    check("gated count", 32'(last_rd >= 38 && last_rd <= 42), 32'h1);
    wr(OFF_LOW_CTRL, 32'h00000000);
    $display("test gated timer done");

    lo = 3 + ($random(seed) & 7);
    wr(OFF_PER_HIGH, 32'h0000FFFF);
    wr(OFF_LOW_COUNT, 32'h00000000);
    wr(OFF_HIGH_COUNT, 32'h00000000);
    wr(OFF_HIGH_CTRL, 32'h00008042);
    for (int i = 0; i < lo; i++) begin
      ext_high <= 1'b1;
      repeat (4) @(posedge mclk);
      ext_high <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    repeat (6) @(posedge mclk);
    rd(OFF_HIGH_COUNT, 32'(lo));
    rd(OFF_LOW_COUNT, 32'h00000000);
    wr(OFF_HIGH_COUNT, 32'h00000000);
    cpu_idle <= 1'b1;
    wr(OFF_HIGH_CTRL, 32'h0000A000);
    repeat (10) @(posedge mclk);
    rd(OFF_HIGH_COUNT, 32'h00000000);
    cpu_idle <= 1'b0;
    repeat (10) @(posedge mclk);
    xfer(OFF_HIGH_COUNT, 1'b0, 32'h0, 1'b0);
    check("idle resume", 32'(last_rd >= 7 && last_rd <= 11), 32'h1);
    $display("test external counter done");
    repeat (4) @(posedge mclk);
    complete_run();
  end
endmodule
